// [hdl/timer8_cfg.svh]
// holds the offsets, field positions, reset values and counts of the timer
// assumes it is included by its bare name from the timer design file
`ifndef TIMER8_CFG_SVH
`define TIMER8_CFG_SVH
// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define T8_OFF_CTRL_A   8'h00
`define T8_OFF_CTRL_B   8'h04
`define T8_OFF_COUNT    8'h08
`define T8_OFF_CMP_A    8'h0c
`define T8_OFF_CMP_B    8'h10
`define T8_OFF_FLAGS    8'h14
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define T8_ACT_A_HI     7
`define T8_ACT_A_LO     6
`define T8_ACT_B_HI     5
`define T8_ACT_B_LO     4
`define T8_FORCE_A      7
`define T8_FORCE_B      6
`define T8_TOP_SEL      3
`define T8_CLK_HI       2
`define T8_WRAP_BIT     0
`define T8_MATCH_A_BIT  1
`define T8_MATCH_B_BIT  2
// ----------------------------------------------------------------------
// values
// ----------------------------------------------------------------------
`define T8_MAX          8'hff
`define T8_BOTTOM       8'h00
`define T8_RST_BYTE     8'h00
`define T8_ZERO_WORD    32'h0000_0000
`define T8_PS_8         10'h007
`define T8_PS_64        10'h03f
`define T8_PS_256       10'h0ff
`define T8_PS_1024      10'h3ff
`endif

// [hdl/timer8_pkg.sv]
// holds the types shared by the timer design
// assumes nothing of its surroundings
package timer8_pkg;
    // waveform modes as {top_select_bit, low mode bits}
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_PC_MAX = 3'h1,
        MODE_CTC    = 3'h2,
        MODE_FAST   = 3'h3,
        MODE_RSV4   = 3'h4,
        MODE_PC_CMP = 3'h5,
        MODE_RSV6   = 3'h6,
        MODE_FAST_A = 3'h7
    } wave_mode_t;
    // output actions on a compare match
    typedef enum logic [1:0] {
        ACT_NONE   = 2'h0,
        ACT_TOGGLE = 2'h1,
        ACT_CLEAR  = 2'h2,
        ACT_SET    = 2'h3
    } action_t;
    // timer clock sources
    typedef enum logic [2:0] {
        CLK_STOP = 3'h0,
        CLK_DIV1 = 3'h1,
        CLK_DIV8 = 3'h2,
        CLK_D64  = 3'h3,
        CLK_D256 = 3'h4,
        CLK_D1K  = 3'h5,
        CLK_EXTF = 3'h6,
        CLK_EXTR = 3'h7
    } clk_src_t;
endpackage

// [hdl/timer8_compare_waveform.sv]
// holds the 8-bit timer with two compare channels and an apb register slave
// assumes an apb master on pclk and the port logic feeding pin data/dir
//
// Functional notes
// - counter write blocks matches next tick
// - output latches keep level on mode change
// - action setting used at next match directly
// - reset clears both output latches
// - nonzero action overrides port data value
// - action zero leaves latch unchanged
// - force strobe applies action in non-pwm
// - counting depends only on wave mode
// - normal mode counts up, wraps ff to 00
// - normal wrap sets flag, never clears
// - ctc clears counter on match a
// - ctc compare a written straight through
// - ctc missed match runs to ff, wraps
// - ctc toggle on every match a
// - ctc wrap flag on max to zero
// - fast pwm single slope, top ff or a
// - fast pwm clears tick after top
// - fast pwm action 2/3 polarity at bottom
// - fast pwm toggle for a only, in mode 7
// - fast pwm flag set at top
// - fast pwm extreme compare values
// - fast pwm compares double buffered
// - match sets flag, write one clears
// - buffers load at top in fast pwm, direct outside pwm
// - counter write beats count or clear
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "timer8_cfg.svh"
module timer8_compare_waveform
    import timer8_pkg::*;
#(
    parameter int ADDR_W = 8      // apb address width
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // external timer clock enable and interrupt acknowledges
    input  wire logic              ext_tick,
    input  wire logic              ack_wrap,
    input  wire logic              ack_match_a,
    input  wire logic              ack_match_b,
    // port logic for the two pins
    input  wire logic              port_data_a,
    input  wire logic              port_dir_a,
    input  wire logic              port_data_b,
    input  wire logic              port_dir_b,
    output logic                   pin_a_out,
    output logic                   pin_a_oe_n,
    output logic                   pin_b_out,
    output logic                   pin_b_oe_n,
    // flags and latches
    output logic                   wrap_flag,
    output logic                   match_flag_a,
    output logic                   match_flag_b,
    output logic                   wave_out_a,
    output logic                   wave_out_b
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    action_t    out_action_sel_a;      // channel a action
    action_t    out_action_sel_b;      // channel b action
    logic [1:0] wave_mode_lo;          // low mode bits
    logic       top_select_bit;        // high mode bit
    clk_src_t   clock_source_sel;      // timer clock source
    logic [7:0] count_value;           // counter
    logic [7:0] compare_value_a;       // active compare a
    logic [7:0] compare_value_b;       // active compare b
    logic [7:0] buf_a;                 // cpu side compare a
    logic [7:0] buf_b;                 // cpu side compare b
    logic       block;                 // matches blocked for next tick
    logic [9:0] presc;                 // free prescaler
    // next values
    action_t    next_act_a;
    action_t    next_act_b;
    logic [1:0] next_mode_lo;
    logic       next_top_sel;
    clk_src_t   next_clk_sel;
    logic [7:0] next_count;
    logic [7:0] next_cmp_a;
    logic [7:0] next_cmp_b;
    logic [7:0] next_buf_a;
    logic [7:0] next_buf_b;
    logic       next_block;
    logic [9:0] next_presc;
    logic       next_wrap;
    logic       next_mfa;
    logic       next_mfb;
    logic       next_wave_a;
    logic       next_wave_b;
    logic [31:0] next_prdata;
    logic       next_pready;
    logic       next_pslverr;
    // decoded conditions
    wave_mode_t mode;                  // full mode number
    logic       is_ctc;                // clear on match a
    logic       is_fast;               // single slope pwm
    logic       is_pwm;                // any pwm mode
    logic [7:0] top_val;               // top of the sequence
    logic       at_top;                // counter sits on top
    logic       tick;                  // timer clock enable
    logic       ev_a;                  // qualified match a
    logic       ev_b;                  // qualified match b
    logic       bottom_ev;             // top to bottom step
    logic       wrap_ev;               // wrap flag event
    logic       force_a;               // forced match a
    logic       force_b;               // forced match b
    logic       wr;                    // apb write commits
    logic       wr_count;              // counter written

    // ------------------------------------------------------------------
    // output action of one channel
    // ------------------------------------------------------------------
    function automatic logic apply(
        input logic    cur,
        input action_t act,
        input logic    fast,
        input logic    tog_ok,
        input logic    match,
        input logic    bottom,
        input logic    cmp_is_top
    );
        logic res;
        res = cur;
        if (!fast) begin
            // set, clear or toggle on match
            if (match) begin
                case (act)
                    ACT_TOGGLE: res = ~cur;
                    ACT_CLEAR:  res = 1'b0;
                    ACT_SET:    res = 1'b1;
                    default:    res = cur;   // no action
                endcase
            end
        end else if (act == ACT_TOGGLE) begin
            // toggle only where offered
            if (match && tog_ok) begin
                res = ~cur;
            end
        end else if (act[1]) begin
            // polarity at bottom wins; match on top ignored
            if (bottom) begin
                res = (act == ACT_CLEAR);
            end else if (match && !cmp_is_top) begin
                res = (act == ACT_SET);
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // decode of mode, timer clock and events
    // ------------------------------------------------------------------
    always_comb begin
        mode    = wave_mode_t'({top_select_bit, wave_mode_lo});
        // counting depends on mode bits only
        is_ctc  = (mode == MODE_CTC);
        is_fast = (mode == MODE_FAST) || (mode == MODE_FAST_A);
        is_pwm  = wave_mode_lo[0];
        // top is max, or compare a in ctc and mode 7
        if (is_ctc || mode == MODE_FAST_A) begin
            top_val = compare_value_a;
        end else begin
            top_val = `T8_MAX;
        end
        at_top = (count_value == top_val);
        case (clock_source_sel)
            CLK_STOP: tick = 1'b0;
            CLK_DIV1: tick = 1'b1;
            CLK_DIV8: tick = (presc & `T8_PS_8) == `T8_PS_8;
            CLK_D64:  tick = (presc & `T8_PS_64) == `T8_PS_64;
            CLK_D256: tick = (presc & `T8_PS_256) == `T8_PS_256;
            CLK_D1K:  tick = (presc & `T8_PS_1024) == `T8_PS_1024;
            default:  tick = ext_tick;
        endcase
        // a blocked tick loses its matches
        ev_a = tick && !block && (count_value == compare_value_a);
        ev_b = tick && !block && (count_value == compare_value_b);
        // fast pwm restarts after top
        bottom_ev = tick && is_fast && at_top;
        if (is_fast) begin
            wrap_ev = tick && at_top;
        end else begin
            wrap_ev = tick && (count_value == `T8_MAX);
        end
        wr       = psel && penable && pready && pwrite;
        wr_count = wr && (paddr[7:0] == `T8_OFF_COUNT);
        // force only outside pwm, no flag, no clear
        force_a = wr && !is_pwm && (paddr[7:0] == `T8_OFF_CTRL_B)
                  && pwdata[`T8_FORCE_A];
        force_b = wr && !is_pwm && (paddr[7:0] == `T8_OFF_CTRL_B)
                  && pwdata[`T8_FORCE_B];
    end

    // ------------------------------------------------------------------
    // next values of settings, counter, block, prescaler, compares and buffers
    // ------------------------------------------------------------------
    always_comb begin
        next_act_a   = out_action_sel_a;
        next_act_b   = out_action_sel_b;
        next_mode_lo = wave_mode_lo;
        next_top_sel = top_select_bit;
        next_clk_sel = clock_source_sel;
        next_cmp_a   = compare_value_a;
        next_cmp_b   = compare_value_b;
        next_buf_a   = buf_a;
        next_buf_b   = buf_b;
        next_presc   = presc + 10'h001;
        // counter: write first, then clear, then count
        if (wr_count) begin
            next_count = pwdata[7:0];
        end else if (tick && ((is_ctc && !block) || is_fast) && at_top) begin
            // ctc: match a clears unless blocked; fast pwm: top clears; b never does
            next_count = `T8_BOTTOM;
        end else if (tick) begin
            // plain increment wraps ff to 00
            next_count = count_value + 8'h01;
        end else begin
            next_count = count_value;
        end
        // block lasts until the next tick
        if (wr_count) begin
            next_block = 1'b1;
        end else if (tick) begin
            next_block = 1'b0;
        end else begin
            next_block = block;
        end
        // load buffers at top in fast pwm
        if (bottom_ev) begin
            next_cmp_a = buf_a;
            next_cmp_b = buf_b;
        end
        // register writes
        if (wr) begin
            if (paddr[7:0] == `T8_OFF_CTRL_A) begin
                // action used at once, no buffering
                next_act_a = action_t'(pwdata[`T8_ACT_A_HI:`T8_ACT_A_LO]);
                next_act_b = action_t'(pwdata[`T8_ACT_B_HI:`T8_ACT_B_LO]);
                next_mode_lo = pwdata[1:0];
            end else if (paddr[7:0] == `T8_OFF_CTRL_B) begin
                next_top_sel = pwdata[`T8_TOP_SEL];
                next_clk_sel = clk_src_t'(pwdata[`T8_CLK_HI:0]);
            end else if (paddr[7:0] == `T8_OFF_CMP_A) begin
                next_buf_a = pwdata[7:0];
                if (!is_pwm) begin
                    next_cmp_a = pwdata[7:0];
                end
            end else if (paddr[7:0] == `T8_OFF_CMP_B) begin
                next_buf_b = pwdata[7:0];
                if (!is_pwm) begin
                    next_cmp_b = pwdata[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // flags and output latches; set wins over clear
    // ------------------------------------------------------------------
    always_comb begin
        logic clr_w;
        logic clr_a;
        logic clr_b;
        logic wf;
        wf    = wr && (paddr[7:0] == `T8_OFF_FLAGS);
        clr_w = ack_wrap || (wf && pwdata[`T8_WRAP_BIT]);
        clr_a = ack_match_a || (wf && pwdata[`T8_MATCH_A_BIT]);
        clr_b = ack_match_b || (wf && pwdata[`T8_MATCH_B_BIT]);
        next_wrap = (wrap_flag && !clr_w) || wrap_ev;
        next_mfa  = (match_flag_a && !clr_a) || ev_a;
        next_mfb  = (match_flag_b && !clr_b) || ev_b;
        // latches only move on match, bottom or force
        next_wave_a = apply(wave_out_a, out_action_sel_a, is_fast,
                            top_select_bit, ev_a || force_a, bottom_ev,
                            compare_value_a == top_val);
        next_wave_b = apply(wave_out_b, out_action_sel_b, is_fast,
                            1'b0, ev_b || force_b, bottom_ev,
                            compare_value_b == top_val);
    end

    // ------------------------------------------------------------------
    // apb answer, zero wait state, read data taken in setup cycle
    // ------------------------------------------------------------------
    always_comb begin
        next_pready  = psel && !penable;
        next_pslverr = 1'b0;
        next_prdata  = `T8_ZERO_WORD;
        if (psel && !penable) begin
            if (paddr[7:0] == `T8_OFF_CTRL_A) begin
                next_prdata[7:0] = {out_action_sel_a, out_action_sel_b,
                                    2'h0, wave_mode_lo};
            end else if (paddr[7:0] == `T8_OFF_CTRL_B) begin
                next_prdata[7:0] = {4'h0, top_select_bit, clock_source_sel};
            end else if (paddr[7:0] == `T8_OFF_COUNT) begin
                next_prdata[7:0] = count_value;
            end else if (paddr[7:0] == `T8_OFF_CMP_A) begin
                next_prdata[7:0] = buf_a;
            end else if (paddr[7:0] == `T8_OFF_CMP_B) begin
                next_prdata[7:0] = buf_b;
            end else if (paddr[7:0] == `T8_OFF_FLAGS) begin
                next_prdata[7:0] = {5'h00, match_flag_b, match_flag_a,
                                    wrap_flag};
            end else begin
                next_pslverr = 1'b1;      // unmapped address
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_action_sel_a <= ACT_NONE;
            out_action_sel_b <= ACT_NONE;
            wave_mode_lo     <= 2'h0;
            top_select_bit   <= 1'b0;
            clock_source_sel <= CLK_STOP;
            count_value      <= `T8_RST_BYTE;
            compare_value_a  <= `T8_RST_BYTE;
            compare_value_b  <= `T8_RST_BYTE;
            buf_a            <= `T8_RST_BYTE;
            buf_b            <= `T8_RST_BYTE;
            block            <= 1'b0;
            presc            <= 10'h000;
            wrap_flag        <= 1'b0;
            match_flag_a     <= 1'b0;
            match_flag_b     <= 1'b0;
            wave_out_a       <= 1'b0;
            wave_out_b       <= 1'b0;
            pin_a_out        <= 1'b0;
            pin_a_oe_n       <= 1'b1;
            pin_b_out        <= 1'b0;
            pin_b_oe_n       <= 1'b1;
            prdata           <= `T8_ZERO_WORD;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
        end else begin
            out_action_sel_a <= next_act_a;
            out_action_sel_b <= next_act_b;
            wave_mode_lo     <= next_mode_lo;
            top_select_bit   <= next_top_sel;
            clock_source_sel <= next_clk_sel;
            count_value      <= next_count;
            compare_value_a  <= next_cmp_a;
            compare_value_b  <= next_cmp_b;
            buf_a            <= next_buf_a;
            buf_b            <= next_buf_b;
            block            <= next_block;
            presc            <= next_presc;
            wrap_flag        <= next_wrap;
            match_flag_a     <= next_mfa;
            match_flag_b     <= next_mfb;
            wave_out_a       <= next_wave_a;
            wave_out_b       <= next_wave_b;
            // compare latch replaces port value when action set
            pin_a_out  <= (out_action_sel_a != ACT_NONE) ? wave_out_a
                                                          : port_data_a;
            pin_b_out  <= (out_action_sel_b != ACT_NONE) ? wave_out_b
                                                          : port_data_b;
            pin_a_oe_n <= !port_dir_a;
            pin_b_oe_n <= !port_dir_b;
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_count_write;
        wr_count;
    endsequence
    sequence s_blocked_tick;
        block && tick;
    endsequence

    a_count_write_wins: assert property (s_count_write |=>
        count_value == $past(pwdata[7:0]))
        else $error("counter write lost");
    a_block_armed: assert property (s_count_write |=> block)
        else $error("counter write did not arm block");
    a_match_blocked: assert property (
        s_blocked_tick |=> !$rose(match_flag_a) && !$rose(match_flag_b))
        else $error("match seen after counter write");
    a_normal_wrap: assert property (
        mode == MODE_NORMAL && tick && count_value == `T8_MAX && !wr_count
        |=> count_value == `T8_BOTTOM && wrap_flag)
        else $error("normal wrap wrong");
    a_ctc_clear: assert property (
        is_ctc && tick && at_top && !wr_count && !block
        |=> count_value == `T8_BOTTOM)
        else $error("ctc did not clear");
    a_match_flag_set: assert property (ev_a |=> match_flag_a)
        else $error("match flag a not set");
    a_fast_noninv: assert property (
        bottom_ev && out_action_sel_a == ACT_CLEAR |=> wave_out_a)
        else $error("noninverting pwm not set at bottom");
    a_pin_override: assert property (
        out_action_sel_a != ACT_NONE |=> pin_a_out == $past(wave_out_a))
        else $error("pin not overridden");
    a_latch_hold: assert property (
        !tick && !force_a |=> $stable(wave_out_a))
        else $error("latch moved without event");
    a_force_set: assert property (
        force_a && out_action_sel_a == ACT_SET |=> wave_out_a)
        else $error("force did not apply");
endmodule

// [verif/port_model.sv]
// partner: port pin logic and external timer clock source
// assumes the bench calls its tasks from one process only
`timescale 1ns/100ps
module port_model (
    // clock
    input  wire logic pclk,
    // towards the timer
    output logic      ext_tick,
    output logic      ack_wrap,
    output logic      ack_match_a,
    output logic      ack_match_b,
    output logic      port_data_a,
    output logic      port_dir_a,
    output logic      port_data_b,
    output logic      port_dir_b
);
    // idle: no tick, no acknowledge, pins as inputs
    initial begin
        {ext_tick, ack_wrap, ack_match_a, ack_match_b} = 4'h0;
        {port_data_a, port_dir_a, port_data_b, port_dir_b} = 4'h0;
    end
    // one-cycle timer clock enable per tick, then let outputs settle
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge pclk) ext_tick <= 1'b1;
            @(posedge pclk) ext_tick <= 1'b0;
        end
        @(negedge pclk);
    endtask
    // interrupt-serviced pulse, bits {b, a, wrap}
    task automatic ack(input logic [2:0] which);
        @(posedge pclk) {ack_match_b, ack_match_a, ack_wrap} <= which;
        @(posedge pclk) {ack_match_b, ack_match_a, ack_wrap} <= 3'h0;
        @(negedge pclk);
    endtask
    // port value and direction, {data_a, dir_a, data_b, dir_b}
    task automatic port(input logic [3:0] v);
        @(posedge pclk) {port_data_a, port_dir_a, port_data_b, port_dir_b} <= v;
    endtask
endmodule

// [verif/timer8_compare_waveform_bench.sv]
// directed bench: apb tasks, port model, compare and flag checks
// assumes the timer package, its header and the port model are compiled
`timescale 1ns/100ps
`include "timer8_cfg.svh"
module timer8_compare_waveform_bench;
    import timer8_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        err, ext_tick, ack_wrap, ack_match_a, ack_match_b;
    logic        port_data_a, port_dir_a, port_data_b, port_dir_b;
    logic        pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n;
    logic        wrap_flag, match_flag_a, match_flag_b;
    logic        wave_out_a, wave_out_b;
    int          fails = 0, n_checks = 0, cyc = 0;
    // ------------------------------------------------------------
    // design and far side
    // ------------------------------------------------------------
    timer8_compare_waveform DUT (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_tick,
        .ack_wrap, .ack_match_a, .ack_match_b, .port_data_a, .port_dir_a,
        .port_data_b, .port_dir_b, .pin_a_out, .pin_a_oe_n, .pin_b_out,
        .pin_b_oe_n, .wrap_flag, .match_flag_a, .match_flag_b,
        .wave_out_a, .wave_out_b);
    port_model PM (.pclk, .ext_tick, .ack_wrap, .ack_match_a,
        .ack_match_b, .port_data_a, .port_dir_a, .port_data_b, .port_dir_b);
    // clock at 4 ns and a hang guard
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            stop_test;
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // compare any value, unknown bits must match exactly
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // latches and flags as {wave_b, wave_a, match_b, match_a, wrap}
    task automatic st(input logic [4:0] e);
        chk({wave_out_b, wave_out_a, match_flag_b, match_flag_a,
             wrap_flag}, e);
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        chk(pready, 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, {24'h0, e});
    endtask
    // let registered pin outputs catch up
    task automatic settle;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    // ------------------------------------------------------------
    // main sequence, timer clocked by ext_tick (source 6)
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        st(5'b00000);
        chk({pin_a_oe_n, pin_b_oe_n}, 2'b11);
        apb(1'b0, 8'h20, 32'h0);
        chk({err, q}, {1'b1, 32'h0});
        // normal mode wrap, flags of both channels
        wr(`T8_OFF_COUNT, 8'hfe);
        wr(`T8_OFF_CTRL_B, 8'h06);
        PM.tick(1);
        rd(`T8_OFF_COUNT, 8'hff);
        PM.tick(1);
        st(5'b00001);
        rd(`T8_OFF_COUNT, 8'h00);
        PM.tick(1);
        st(5'b00111);
        wr(`T8_OFF_FLAGS, 8'h01);
        st(5'b00110);
        PM.ack(3'b110);
        st(5'b00000);
        // forced compare and port override
        PM.port(4'b0111);
        wr(`T8_OFF_CTRL_A, 8'hc0);
        wr(`T8_OFF_CTRL_B, 8'h86);
        settle;
        st(5'b01000);
        chk({pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n}, 4'ha);
        wr(`T8_OFF_CTRL_A, 8'h00);
        PM.port(4'b0100);
        settle;
        chk({pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n}, 4'h1);
        // clear on match with toggle, blocked match, missed match
        wr(`T8_OFF_CTRL_A, 8'h42);
        st(5'b01000);
        wr(`T8_OFF_CMP_A, 8'h02);
        wr(`T8_OFF_COUNT, 8'h00);
        PM.tick(3);
        st(5'b00010);
        rd(`T8_OFF_COUNT, 8'h00);
        PM.tick(3);
        st(5'b01110);
        wr(`T8_OFF_FLAGS, 8'h07);
        wr(`T8_OFF_COUNT, 8'h02);
        PM.tick(1);
        rd(`T8_OFF_COUNT, 8'h03);
        PM.tick(253);
        rd(`T8_OFF_COUNT, 8'h00);
        st(5'b01001);
        // fast pwm, non-inverting then inverting
        PM.ack(3'b111);
        st(5'b01000);
        for (int i = 2; i < 4; i++) begin
            wr(`T8_OFF_CTRL_A, {i[1:0], 6'h03});
            wr(`T8_OFF_COUNT, 8'hfe);
            wr(`T8_OFF_CMP_A, 8'h01);
            PM.tick(2);
            rd(`T8_OFF_COUNT, 8'h00);
            chk(wave_out_a, !i[0]);
            PM.tick(2);
            chk(wave_out_a, i[0]);
        end
        chk(wrap_flag, 1'b1);
        // a buffered compare write must not act before top
        wr(`T8_OFF_CTRL_A, 8'h83);
        wr(`T8_OFF_CMP_A, 8'h03);
        PM.tick(2);
        chk(wave_out_a, 1'b1);
        stop_test;
    end
endmodule
